// file: inc/sdc_pkg.sv
// package of offsets, field layouts, reset values and timing for the synth divider config block
package sdc_pkg;

  // ---------------------------------------------------------------
  // register map: printed offsets are register indices, byte addr = 4 * index
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int IDX_W = 6;
  localparam logic [IDX_W-1:0] IDX_A_REF = 6'h34;
  localparam logic [IDX_W-1:0] IDX_A_M = 6'h35;
  localparam logic [IDX_W-1:0] IDX_B_REF = 6'h36;
  localparam logic [IDX_W-1:0] IDX_B_M = 6'h37;
  localparam logic [IDX_W-1:0] IDX_A_CTRL0 = 6'h38;
  localparam logic [IDX_W-1:0] IDX_A_STATUS = 6'h39;

  // ---------------------------------------------------------------
  // field layouts
  // ---------------------------------------------------------------
  localparam int REF_DIV_W = 3;
  localparam int M_DIV_W = 5;
  localparam int POST_LSB = 2;
  localparam int POST_W = 3;
  localparam int SYNC_BIT = 1;
  localparam int PDN_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_EN_BIT = 1;
  localparam int STAT_DONE_BIT = 2;
  localparam logic [7:0] MASK_REF = 8'h07;
  localparam logic [7:0] MASK_M = 8'h1f;
  localparam logic [7:0] MASK_CTRL0 = 8'h1f;

  // ---------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_A_REF = 8'h00;
  localparam logic [7:0] RST_A_M = 8'h00;
  localparam logic [7:0] RST_B_REF = 8'h00;
  localparam logic [7:0] RST_B_M = 8'h00;
  localparam logic [7:0] RST_A_CTRL0 = 8'h1e;
  localparam logic [3:0] RST_POST_RATIO = 4'h8;

  // ---------------------------------------------------------------
  // post divider decode and calibration timing
  // ---------------------------------------------------------------
  localparam logic [POST_W-1:0] POST_MIN_CODE = 3'h2;
  localparam logic [3:0] POST_MIN_RATIO = 4'h2;
  localparam int CLK_PERIOD_NS = 50;
  localparam int CAL_TIME_NS = 10000;
  localparam int CAL_CYC = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {CAL_OFF, CAL_SEQ, CAL_READY} sdc_cal_e;

endpackage

// file: src/sdc_div_decode.sv
// divider code decode: zero bypasses, code n divides by n+1
`timescale 1ns/1ps
module sdc_div_decode #(
  parameter int W = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // divider code from register
  input wire logic [W-1:0] code,
  // decoded divider setting
  output logic bypass,
  output logic [W:0] ratio
);

  logic bypass_ff;
  logic nxt_bypass;
  logic [W:0] ratio_ff;
  logic [W:0] nxt_ratio;

  always_comb begin
    nxt_bypass = (code == '0);
    nxt_ratio = {1'b0, code} + {{W{1'b0}}, 1'b1};
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bypass_ff <= 1'b1;
      ratio_ff <= {{W{1'b0}}, 1'b1};
    end else begin
      bypass_ff <= nxt_bypass;
      ratio_ff <= nxt_ratio;
    end
  end

  assign bypass = bypass_ff;
  assign ratio = ratio_ff;

endmodule

// file: src/sdc_sync_edge.sv
// two-flop synchroniser for a pin with a registered rising-edge pulse
`timescale 1ns/1ps
module sdc_sync_edge (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // asynchronous pin
  input wire logic pin,
  // one-cycle pulse on a rising edge of the pin
  output logic rise
);

  logic meta_ff;
  logic stable_ff;
  logic last_ff;
  logic rise_ff;
  logic nxt_rise;

  always_comb begin
    nxt_rise = stable_ff & ~last_ff;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= 1'b0;
      stable_ff <= 1'b0;
      last_ff <= 1'b0;
      rise_ff <= 1'b0;
    end else begin
      meta_ff <= pin;
      stable_ff <= meta_ff;
      last_ff <= stable_ff;
      rise_ff <= nxt_rise;
    end
  end

  assign rise = rise_ff;

endmodule

// file: src/sdc_regs.sv
// synth divider config registers with apb slave, sync gating and calibration control
//
// How it works
// - synth A reference pre-divider code 0 bypasses, code n divides by n+1, up to 8.
// - synth A M divider code 0 bypasses, code n divides by n+1, up to 32.
// - synth B reference pre-divider code 0 bypasses, code n divides by n+1, up to 8.
// - synth B M divider code 0 bypasses, code n divides by n+1, up to 32.
// - synth A post divider is 2 for codes 0 and 1, n+1 above, and resets to 8.
// - a sync event resyncs the synth A channels only while sync participation is set.
// - with power-down clear, synth A is enabled and calibrated after reset.
// - setting power-down disables synth A and holds its calibration in reset.
// - clearing power-down restarts calibration with no further software action.
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
module sdc_regs #(
  parameter int NUM_CH = 8,
  parameter int CAL_CYC = sdc_pkg::CAL_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sdc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // sync event pin and channel source map
  input wire logic sync_pin,
  input wire logic [NUM_CH-1:0] ch_from_synth_a,
  output logic [NUM_CH-1:0] ch_resync,
  // decoded divider settings
  output logic a_ref_bypass,
  output logic [3:0] a_ref_ratio,
  output logic a_m_bypass,
  output logic [5:0] a_m_ratio,
  output logic b_ref_bypass,
  output logic [3:0] b_ref_ratio,
  output logic b_m_bypass,
  output logic [5:0] b_m_ratio,
  output logic [3:0] a_post_ratio,
  // synth A power and calibration
  output logic synth_a_enable,
  output logic synth_a_cal_reset,
  output logic synth_a_cal_busy
);

  localparam int CNT_W = $clog2(CAL_CYC + 1);
  localparam logic [CNT_W-1:0] CAL_LAST = CNT_W'(CAL_CYC - 1);

  // ---------------------------------------------------------------
  // register file and apb
  // ---------------------------------------------------------------
  logic [7:0] a_ref_ff;
  logic [7:0] nxt_a_ref;
  logic [7:0] a_m_ff;
  logic [7:0] nxt_a_m;
  logic [7:0] b_ref_ff;
  logic [7:0] nxt_b_ref;
  logic [7:0] b_m_ff;
  logic [7:0] nxt_b_m;
  logic [7:0] a_ctrl_ff;
  logic [7:0] nxt_a_ctrl;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic pready_ff;
  logic nxt_pready;
  logic pslverr_ff;
  logic nxt_pslverr;
  logic [sdc_pkg::IDX_W-1:0] idx;
  logic hit;
  logic wr_ok;
  logic [7:0] rd_mux;
  logic [7:0] status;
  logic setup;
  logic access;

  // ---------------------------------------------------------------
  // calibration sequencer and outputs
  // ---------------------------------------------------------------
  sdc_pkg::sdc_cal_e cal_ff;
  sdc_pkg::sdc_cal_e nxt_cal;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic en_ff;
  logic nxt_en;
  logic cal_rst_ff;
  logic nxt_cal_rst;
  logic busy_ff;
  logic nxt_busy;
  logic [3:0] post_ff;
  logic [3:0] nxt_post;
  logic [NUM_CH-1:0] resync_ff;
  logic [NUM_CH-1:0] nxt_resync;
  logic sync_evt;
  logic pdn;
  logic participate;

  assign pdn = a_ctrl_ff[sdc_pkg::PDN_BIT];
  assign participate = a_ctrl_ff[sdc_pkg::SYNC_BIT];

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  always_comb begin
    idx = paddr[sdc_pkg::ADDR_W-1:2];
    setup = psel & ~penable;
    access = psel & penable & pready_ff;
    status = 8'h00;
    status[sdc_pkg::STAT_BUSY_BIT] = busy_ff;
    status[sdc_pkg::STAT_EN_BIT] = en_ff;
    status[sdc_pkg::STAT_DONE_BIT] = (cal_ff == sdc_pkg::CAL_READY);
    hit = (paddr[1:0] == 2'h0);
    wr_ok = 1'b1;
    case (idx)
      sdc_pkg::IDX_A_REF: rd_mux = a_ref_ff;
      sdc_pkg::IDX_A_M: rd_mux = a_m_ff;
      sdc_pkg::IDX_B_REF: rd_mux = b_ref_ff;
      sdc_pkg::IDX_B_M: rd_mux = b_m_ff;
      sdc_pkg::IDX_A_CTRL0: rd_mux = a_ctrl_ff;
      sdc_pkg::IDX_A_STATUS: begin
        rd_mux = status;
        wr_ok = 1'b0;
      end
      default: begin
        rd_mux = 8'h00;
        hit = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // register writes and read answers
  // ---------------------------------------------------------------
  always_comb begin
    nxt_a_ref = a_ref_ff;
    nxt_a_m = a_m_ff;
    nxt_b_ref = b_ref_ff;
    nxt_b_m = b_m_ff;
    nxt_a_ctrl = a_ctrl_ff;
    nxt_pready = setup;
    nxt_pslverr = setup & ~hit;
    nxt_prdata = 32'h0000_0000;
    if (setup && !pwrite && hit) begin
      nxt_prdata = {24'h00_0000, rd_mux};
    end
    if (access && pwrite && pstrb[0] && hit && wr_ok) begin
      case (idx)
        sdc_pkg::IDX_A_REF: nxt_a_ref = pwdata[7:0] & sdc_pkg::MASK_REF;
        sdc_pkg::IDX_A_M: nxt_a_m = pwdata[7:0] & sdc_pkg::MASK_M;
        sdc_pkg::IDX_B_REF: nxt_b_ref = pwdata[7:0] & sdc_pkg::MASK_REF;
        sdc_pkg::IDX_B_M: nxt_b_m = pwdata[7:0] & sdc_pkg::MASK_M;
        sdc_pkg::IDX_A_CTRL0: nxt_a_ctrl = pwdata[7:0] & sdc_pkg::MASK_CTRL0;
        default: nxt_a_ctrl = a_ctrl_ff;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      a_ref_ff <= sdc_pkg::RST_A_REF;
      a_m_ff <= sdc_pkg::RST_A_M;
      b_ref_ff <= sdc_pkg::RST_B_REF;
      b_m_ff <= sdc_pkg::RST_B_M;
      a_ctrl_ff <= sdc_pkg::RST_A_CTRL0;
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      a_ref_ff <= nxt_a_ref;
      a_m_ff <= nxt_a_m;
      b_ref_ff <= nxt_b_ref;
      b_m_ff <= nxt_b_m;
      a_ctrl_ff <= nxt_a_ctrl;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  // ---------------------------------------------------------------
  // divider decode
  // ---------------------------------------------------------------
  sdc_div_decode #(.W(sdc_pkg::REF_DIV_W)) u_a_ref (
    .clk(clk),
    .rst(rst),
    .code(a_ref_ff[sdc_pkg::REF_DIV_W-1:0]),
    .bypass(a_ref_bypass),
    .ratio(a_ref_ratio)
  );

  sdc_div_decode #(.W(sdc_pkg::M_DIV_W)) u_a_m (
    .clk(clk),
    .rst(rst),
    .code(a_m_ff[sdc_pkg::M_DIV_W-1:0]),
    .bypass(a_m_bypass),
    .ratio(a_m_ratio)
  );

  sdc_div_decode #(.W(sdc_pkg::REF_DIV_W)) u_b_ref (
    .clk(clk),
    .rst(rst),
    .code(b_ref_ff[sdc_pkg::REF_DIV_W-1:0]),
    .bypass(b_ref_bypass),
    .ratio(b_ref_ratio)
  );

  sdc_div_decode #(.W(sdc_pkg::M_DIV_W)) u_b_m (
    .clk(clk),
    .rst(rst),
    .code(b_m_ff[sdc_pkg::M_DIV_W-1:0]),
    .bypass(b_m_bypass),
    .ratio(b_m_ratio)
  );

  // ---------------------------------------------------------------
  // sync event gating
  // ---------------------------------------------------------------
  sdc_sync_edge u_sync (
    .clk(clk),
    .rst(rst),
    .pin(sync_pin),
    .rise(sync_evt)
  );

  generate
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      always_comb begin
        nxt_resync[i] = sync_evt & participate & ch_from_synth_a[i];
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // post divider and calibration sequencer
  // ---------------------------------------------------------------
  always_comb begin
    if (a_ctrl_ff[sdc_pkg::POST_LSB +: sdc_pkg::POST_W] < sdc_pkg::POST_MIN_CODE) begin
      nxt_post = sdc_pkg::POST_MIN_RATIO;
    end else begin
      nxt_post = {1'b0, a_ctrl_ff[sdc_pkg::POST_LSB +: sdc_pkg::POST_W]} + 4'h1;
    end
    nxt_cal = cal_ff;
    nxt_cnt = cnt_ff;
    case (cal_ff)
      sdc_pkg::CAL_OFF: begin
        if (!pdn) begin
          nxt_cal = sdc_pkg::CAL_SEQ;
          nxt_cnt = '0;
        end
      end
      sdc_pkg::CAL_SEQ: begin
        if (cnt_ff == CAL_LAST) begin
          nxt_cal = sdc_pkg::CAL_READY;
        end else begin
          nxt_cnt = cnt_ff + CNT_W'(1);
        end
      end
      sdc_pkg::CAL_READY: nxt_cal = sdc_pkg::CAL_READY;
      default: nxt_cal = sdc_pkg::CAL_OFF;
    endcase
    if (pdn) begin
      nxt_cal = sdc_pkg::CAL_OFF;
      nxt_cnt = '0;
    end
    nxt_en = (nxt_cal != sdc_pkg::CAL_OFF);
    nxt_cal_rst = (nxt_cal == sdc_pkg::CAL_OFF);
    nxt_busy = (nxt_cal == sdc_pkg::CAL_SEQ);
  end

  // reset leaves power-down clear, so calibration starts straight out of reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cal_ff <= sdc_pkg::CAL_SEQ;
      cnt_ff <= '0;
      en_ff <= 1'b1;
      cal_rst_ff <= 1'b0;
      busy_ff <= 1'b1;
      post_ff <= sdc_pkg::RST_POST_RATIO;
      resync_ff <= '0;
    end else begin
      cal_ff <= nxt_cal;
      cnt_ff <= nxt_cnt;
      en_ff <= nxt_en;
      cal_rst_ff <= nxt_cal_rst;
      busy_ff <= nxt_busy;
      post_ff <= nxt_post;
      resync_ff <= nxt_resync;
    end
  end

  assign synth_a_enable = en_ff;
  assign synth_a_cal_reset = cal_rst_ff;
  assign synth_a_cal_busy = busy_ff;
  assign a_post_ratio = post_ff;
  assign ch_resync = resync_ff;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  AST_A_REF_DIV: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> (a_ref_bypass == ($past(a_ref_ff[2:0]) == 3'h0))
      && (a_ref_ratio == {1'b0, $past(a_ref_ff[2:0])} + 4'h1))
    else $error("synth A reference divider decode wrong");

  AST_A_M_DIV: assert property (@(posedge clk) disable iff (rst)
    (a_m_ff[4:0] == 5'h1f) |=> (a_m_ratio == 6'h20) && !a_m_bypass)
    else $error("synth A M divider top code not divide by 32");

  AST_B_REF_DIV: assert property (@(posedge clk) disable iff (rst)
    (b_ref_ff[2:0] == 3'h0) |=> b_ref_bypass && (b_ref_ratio == 4'h1))
    else $error("synth B reference divider not bypassed at code zero");

  AST_B_M_DIV: assert property (@(posedge clk) disable iff (rst)
    $changed(b_m_ff) |=> (b_m_ratio == {1'b0, $past(b_m_ff[4:0])} + 6'h1)
      && (b_m_bypass == ($past(b_m_ff[4:0]) == 5'h0)))
    else $error("synth B M divider ratio not code plus one");

  AST_POST_DIV: assert property (@(posedge clk) disable iff (rst)
    (a_ctrl_ff[4:2] < 3'h2) |=> (a_post_ratio == 4'h2))
    else $error("synth A post divider not two for low codes");

  AST_SYNC_GATE: assert property (@(posedge clk) disable iff (rst)
    sync_evt |=> (ch_resync == ($past(ch_from_synth_a) & {NUM_CH{$past(participate)}})))
    else $error("sync event not gated by participation");

  AST_CAL_AFTER_RST: assert property (@(posedge clk) disable iff (rst)
    $past(rst) && !pdn |-> synth_a_enable && synth_a_cal_busy && !synth_a_cal_reset)
    else $error("calibration not started after reset");

  AST_PDN_HOLD: assert property (@(posedge clk) disable iff (rst)
    pdn [*2] |-> !synth_a_enable && synth_a_cal_reset && !synth_a_cal_busy)
    else $error("power-down did not disable synth A");

  AST_CAL_RESTART: assert property (@(posedge clk) disable iff (rst)
    $fell(pdn) |=> synth_a_cal_busy && synth_a_enable)
    else $error("calibration not restarted on power-up");

  AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (rst)
    (prdata[31:8] == 24'h0) && (a_ref_ff[7:3] == 5'h0) && (a_ctrl_ff[7:5] == 3'h0))
    else $error("reserved bits not zero");

endmodule

// file: sim/sdc_regs_bench.sv
// self-checking bench for the synth divider config registers
`timescale 1ns/1ps
module sdc_regs_bench;
  localparam int CAL = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready, pslverr, sync_pin = 1'b0;
  logic [7:0] ch_map = 8'ha5;
  logic [7:0] ch_resync;
  logic a_ref_bypass, a_m_bypass, b_ref_bypass, b_m_bypass;
  logic [3:0] a_ref_ratio, b_ref_ratio, a_post_ratio;
  logic [5:0] a_m_ratio, b_m_ratio;
  logic synth_a_enable, synth_a_cal_reset, synth_a_cal_busy;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic er;
  logic [5:0] idx [4];
  logic [7:0] msk [4];
  logic [7:0] wv [4];

  sdc_regs #(.NUM_CH(8), .CAL_CYC(CAL)) dut (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sync_pin(sync_pin),
    .ch_from_synth_a(ch_map), .ch_resync(ch_resync), .a_ref_bypass(a_ref_bypass),
    .a_ref_ratio(a_ref_ratio), .a_m_bypass(a_m_bypass), .a_m_ratio(a_m_ratio),
    .b_ref_bypass(b_ref_bypass), .b_ref_ratio(b_ref_ratio), .b_m_bypass(b_m_bypass),
    .b_m_ratio(b_m_ratio), .a_post_ratio(a_post_ratio), .synth_a_enable(synth_a_enable),
    .synth_a_cal_reset(synth_a_cal_reset), .synth_a_cal_busy(synth_a_cal_busy));

  always #25 clk = ~clk;

  // ---------------------------------------------------------------
  // checking and closing
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      complete_run();
    end
  end

  // ---------------------------------------------------------------
  // apb master
  // ---------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [7:0] ba(input logic [5:0] i);
    return {i, 2'b00};
  endfunction

  task automatic div_out(input int k, output logic [6:0] v);
    case (k)
      0: v = {a_ref_bypass, 2'h0, a_ref_ratio};
      1: v = {a_m_bypass, a_m_ratio};
      2: v = {b_ref_bypass, 2'h0, b_ref_ratio};
      default: v = {b_m_bypass, b_m_ratio};
    endcase
  endtask

  task automatic wait_status(input logic [31:0] exp);
    for (int i = 0; i < CAL + 20; i++) begin
      @(posedge clk);
      if (synth_a_cal_busy === 1'b0) break;
    end
    apb(1'b0, ba(sdc_pkg::IDX_A_STATUS), 8'h00, 4'h0);
    chk(rd, exp);
  endtask

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    logic [6:0] v;
    logic [7:0] c;
    int n;
    idx = '{sdc_pkg::IDX_A_REF, sdc_pkg::IDX_A_M, sdc_pkg::IDX_B_REF, sdc_pkg::IDX_B_M};
    msk = '{8'h07, 8'h1f, 8'h07, 8'h1f};
    wv = '{8'h00, 8'h01, 8'h05, 8'hff};
    repeat (8) @(posedge clk);
    chk({synth_a_enable, synth_a_cal_reset, synth_a_cal_busy}, 32'h5);
    chk(a_post_ratio, 32'h8);
    rst <= 1'b0;
    wait_status(32'h06);
    apb(1'b0, ba(sdc_pkg::IDX_A_CTRL0), 8'h00, 4'h0);
    chk(rd, 32'h1e);
    $display("test reset done");

    for (int k = 0; k < 4; k++) begin
      for (int j = 0; j < 4; j++) begin
        c = wv[j] & msk[k];
        apb(1'b1, ba(idx[k]), wv[j], 4'h1);
        repeat (2) @(posedge clk);
        #1;
        div_out(k, v);
        chk(v, (c == 8'h00) ? 32'h41 : 32'(c) + 1);
        apb(1'b0, ba(idx[k]), 8'h00, 4'h0);
        chk(rd, 32'(c));
      end
    end
    $display("test dividers done");

    for (int p = 0; p < 8; p++) begin
      apb(1'b1, ba(sdc_pkg::IDX_A_CTRL0), 8'(p << 2) | 8'he2, 4'h1);
      repeat (2) @(posedge clk);
      #1;
      chk(a_post_ratio, (p < 2) ? 32'h2 : 32'(p + 1));
      apb(1'b0, ba(sdc_pkg::IDX_A_CTRL0), 8'h00, 4'h0);
      chk(rd, 32'(p << 2) | 32'h2);
    end
    $display("test post divider done");

    for (int s = 1; s >= 0; s--) begin
      apb(1'b1, ba(sdc_pkg::IDX_A_CTRL0), 8'h1c | 8'(s << 1), 4'h1);
      @(posedge clk);
      sync_pin <= 1'b1;
      n = 0;
      for (int i = 0; i < 10; i++) begin
        @(posedge clk);
        #1;
        if (ch_resync !== 8'h00) break;
        n++;
      end
      chk(ch_resync, (s == 1) ? 32'ha5 : 32'h0);
      if (s == 1) begin
        chk(n, 32'h3);
      end
      @(posedge clk);
      sync_pin <= 1'b0;
      #1;
      chk(ch_resync, 32'h0);
      repeat (4) @(posedge clk);
    end
    $display("test sync done");

    apb(1'b1, ba(sdc_pkg::IDX_A_CTRL0), 8'h1d, 4'h1);
    @(posedge clk);
    #1;
    chk({synth_a_enable, synth_a_cal_reset, synth_a_cal_busy}, 32'h2);
    repeat (CAL + 3) @(posedge clk);
    #1;
    chk({synth_a_enable, synth_a_cal_reset, synth_a_cal_busy}, 32'h2);
    apb(1'b1, ba(sdc_pkg::IDX_A_CTRL0), 8'h1c, 4'h1);
    n = 0;
    @(posedge clk);
    for (int i = 0; i < CAL + 10; i++) begin
      @(posedge clk);
      if (synth_a_cal_busy !== 1'b1) break;
      n++;
    end
    chk(n, CAL);
    chk({synth_a_enable, synth_a_cal_reset}, 32'h2);
    wait_status(32'h06);
    $display("test power down done");

    apb(1'b0, 8'h00, 8'h00, 4'h0);
    chk(rd, 32'h0);
    chk(er, 32'h1);
    apb(1'b1, ba(sdc_pkg::IDX_A_REF) | 8'h01, 8'h03, 4'h1);
    chk(er, 32'h1);
    apb(1'b1, ba(sdc_pkg::IDX_A_REF), 8'h02, 4'h0);
    chk(er, 32'h0);
    apb(1'b1, ba(sdc_pkg::IDX_A_STATUS), 8'h00, 4'h1);
    apb(1'b0, ba(sdc_pkg::IDX_A_REF), 8'h00, 4'h0);
    chk(rd, 32'h7);
    apb(1'b0, ba(sdc_pkg::IDX_A_STATUS), 8'h00, 4'h0);
    chk(rd, 32'h06);
    $display("test refusals done");
    complete_run();
  end
endmodule
